// File: adc_ctrl_pkg.sv
// Purpose: shared constants and types for the triple video converter control
// Assumes: one sample clock, inputs synchronous to it
// Notes: dither counter is two bits, one step is half an lsb
package adc_ctrl_pkg;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned CHANNELS      = 3;
	localparam int unsigned DITHER_W      = 2;
	localparam int unsigned FRAME_DIV_W   = 1;
	localparam int unsigned PIPE_RISE     = 3;
	localparam int unsigned CH_GREEN      = 0;
	localparam int unsigned CH_RED        = 1;
	localparam int unsigned CH_BLUE       = 2;
	localparam logic [7:0]  CLAMP_LOW     = 8'h10;
	localparam logic [7:0]  CLAMP_MID     = 8'h40;
	localparam logic [7:0]  CLAMP_HALF    = 8'h80;
	localparam logic [1:0]  DITHER_RESET  = 2'h0;
	localparam logic [7:0]  CODE_MAX      = 8'hFF;
	typedef enum logic [1:0] {
		MODE_LOW,
		MODE_HIGH,
		MODE_OPEN
	} clamp_mode_t;
	typedef enum {
		CLAMP_INTEGRATE,
		CLAMP_CORRECT
	} clamp_phase_t;
endpackage

// File: chan_if.sv
// Purpose: per-channel signals between the control top and a channel
// Assumes: shared clock
// Notes: none
interface chan_if;
	import adc_ctrl_pkg::*;
	logic [7:0] sample;
	logic [7:0] clamp_ref;
	logic [1:0] dither;
	logic       integrate;
	logic       latch_sign;
	logic       sign;
	logic [7:0] code;
	modport top  (output sample, clamp_ref, dither, integrate, latch_sign,
		input sign, code);
	modport chan (input sample, clamp_ref, dither, integrate, latch_sign,
		output sign, code);
endinterface

// File: adc_channel.sv
// Purpose: one channel: sample pipeline, dither correction, clamp integrator
// Assumes: sample already carries the analog dither offset
// Notes: integrator is a signed accumulator
module adc_channel
	import adc_ctrl_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic clk_en,
	chan_if.chan      ch
);
	logic [7:0]  samp_neg;
	logic [7:0]  stage;
	logic [7:0]  code;
	logic [7:0]  next_code;
	logic [1:0]  dith_neg;
	logic [1:0]  dith_stage;
	logic [7:0]  stage_b;
	logic [1:0]  dith_b;
	logic signed [15:0] acc;
	logic signed [15:0] next_acc;
	logic        sign;
	logic        next_sign;

	// sample taken on the falling edge, output only on rising edges
	always_ff @(negedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			samp_neg <= 8'h00;
			dith_neg <= 2'h0;
		end else if (clk_en) begin
			samp_neg <= ch.sample;
			dith_neg <= ch.dither;
		end
	end

	// whole lsb part of the half-lsb dither is subtracted; a zero input is held
	// at the range floor so each pattern state spans 00..FE or 01..FF
	always_comb begin
		next_code = stage_b - {7'h00, dith_b[1]};
		if (stage_b == 8'h00)
			next_code = {7'h00, ~dith_b[1]};
		next_acc = acc;
		next_sign = sign;
		if (ch.integrate)
			next_acc = acc + 16'(signed'({1'b0, ch.sample}))
				- 16'(signed'({1'b0, ch.clamp_ref}));
		if (ch.latch_sign) begin
			next_sign = acc[15];
			next_acc = 16'sh0000;
		end
	end

	// third rising edge after the falling sample: 2.5 cycles in total
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stage      <= 8'h00;
			dith_stage <= 2'h0;
			stage_b    <= 8'h00;
			dith_b     <= 2'h0;
			code       <= 8'h00;
			acc        <= 16'sh0000;
			sign       <= 1'b0;
		end else if (clk_en) begin
			stage      <= samp_neg;
			dith_stage <= dith_neg;
			stage_b    <= stage;
			dith_b     <= dith_stage;
			code       <= next_code;
			acc        <= next_acc;
			sign       <= next_sign;
		end
	end

	assign ch.code = code;
	assign ch.sign = sign;
endmodule

// File: video_adc_dither_clamp_control.sv
// Purpose: common clocking, dither counter and clamp sequencing for three channels
// Assumes: sync inputs synchronous to clk_sys, sample words already digitised
// Notes: data pins are tri-state modelled as data plus active-low enable
// What this block does
// - all channels share clock and sync
// - sample on falling edge, outputs on rising
// - code appears 2.5 cycles after sampling
// - frame sync low stops and disables dither
// - dither counter counts once per line
// - counter reset every second frame sync
// - dither offset steps half an lsb
// - subtract whole-lsb offset from output code
// - correction by binary adder from counter
// - output range 00..FE or 01..FF
// - clamp-select picks per-channel clamp targets
// - integrate input minus reference while line high
// - latch integrator sign on line falling edge
// - sink or source correction while line low
// - output enable low drives, high floats outputs
module video_adc_dither_clamp_control
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  green_in,
	input  wire logic [7:0]  red_in,
	input  wire logic [7:0]  blue_in,
	input  wire logic        line_sync_in,
	input  wire logic        frame_sync_in,
	input  wire clamp_mode_t clamp_mode,
	input  wire logic        out_enable_n,
	output logic [7:0]       green_out,
	output logic [7:0]       red_out,
	output logic [7:0]       blue_out,
	output logic             data_oe_n,
	output logic [1:0]       dither_offset,
	output logic [2:0]       clamp_sink,
	output logic [2:0]       clamp_source
);
	logic [1:0]   dither_cnt;
	logic [1:0]   next_dither_cnt;
	logic         frame_div;
	logic         next_frame_div;
	logic         line_d;
	logic         next_line_d;
	logic         frame_d;
	logic         next_frame_d;
	logic         correcting;
	logic         line_rise;
	logic         line_fall;
	logic         frame_fall;
	clamp_phase_t phase;
	clamp_phase_t next_phase;
	logic [7:0]   ref_green;
	logic [7:0]   ref_chroma;
	logic [7:0]   samp [CHANNELS];
	logic [7:0]   codes [CHANNELS];
	logic [2:0]   signs;

	// edge detectors rest at the idle level of each pin, so a frame pin held
	// high through reset gives no false frame pulse on release
	assign line_rise  = line_sync_in & ~line_d;
	assign line_fall  = ~line_sync_in & line_d;
	assign frame_fall = ~frame_sync_in & frame_d;
	assign samp[CH_GREEN] = green_in;
	assign samp[CH_RED]   = red_in;
	assign samp[CH_BLUE]  = blue_in;

	always_comb begin
		next_line_d  = line_sync_in;
		next_frame_d = frame_sync_in;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			line_d  <= 1'b0;
			frame_d <= 1'b1;
		end else if (clk_en) begin
			line_d  <= next_line_d;
			frame_d <= next_frame_d;
		end
	end

	// a frame pulse takes priority over a line edge in the same cycle, so the
	// pattern restarts cleanly on every second frame boundary
	always_comb begin
		next_dither_cnt = dither_cnt;
		next_frame_div  = frame_div;
		if (frame_fall) begin
			next_frame_div = ~frame_div;
			if (frame_div) begin
				next_dither_cnt = DITHER_RESET;
			end
		end else if (frame_sync_in && line_rise) begin
			next_dither_cnt = dither_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dither_cnt <= DITHER_RESET;
			frame_div  <= 1'b0;
		end else if (clk_en) begin
			dither_cnt <= next_dither_cnt;
			frame_div  <= next_frame_div;
		end
	end

	// correction runs from the line falling edge until line sync rises again
	always_comb begin
		next_phase = phase;
		case (phase)
			CLAMP_INTEGRATE: begin
				if (line_fall) begin
					next_phase = CLAMP_CORRECT;
				end
			end
			CLAMP_CORRECT: begin
				if (line_sync_in) begin
					next_phase = CLAMP_INTEGRATE;
				end
			end
			default: begin
				next_phase = CLAMP_INTEGRATE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase <= CLAMP_INTEGRATE;
		end else if (clk_en) begin
			phase <= next_phase;
		end
	end

	// counter value is the offset in half-lsb units; zero while dither is off
	assign dither_offset = frame_sync_in ? dither_cnt : 2'h0;

	// the unused fourth select code falls back to the all-low setting
	always_comb begin
		case (clamp_mode)
			MODE_LOW: begin
				ref_green  = CLAMP_LOW;
				ref_chroma = CLAMP_LOW;
			end
			MODE_HIGH: begin
				ref_green  = CLAMP_LOW;
				ref_chroma = CLAMP_HALF;
			end
			MODE_OPEN: begin
				ref_green  = CLAMP_MID;
				ref_chroma = CLAMP_HALF;
			end
			default: begin
				ref_green  = CLAMP_LOW;
				ref_chroma = CLAMP_LOW;
			end
		endcase
	end

	// one shared clock and sync for every channel
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		chan_if cif ();
		assign cif.sample     = samp[i];
		assign cif.clamp_ref  = (i == CH_GREEN) ? ref_green : ref_chroma;
		assign cif.dither     = dither_offset;
		assign cif.integrate  = line_sync_in;
		assign cif.latch_sign = line_fall;
		assign codes[i]       = cif.code;
		assign signs[i]       = cif.sign;
		adc_channel u_ch (
			.clk_sys (clk_sys),
			.resetn  (resetn),
			.clk_en  (clk_en),
			.ch      (cif.chan)
		);
	end

	// negative sign means input below reference, so source current to raise it
	assign correcting = (phase == CLAMP_CORRECT) && !line_sync_in;

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			clamp_source[c] = correcting & signs[c];
			clamp_sink[c]   = correcting & ~signs[c];
		end
	end

	assign green_out = codes[CH_GREEN];
	assign red_out   = codes[CH_RED];
	assign blue_out  = codes[CH_BLUE];
	assign data_oe_n = out_enable_n;
endmodule

// File: vadc_checker.sv
// Purpose: port assertions for the converter control
// Assumes: clk_en held high
// Notes: code checks wait three clean edges after reset
module vadc_checker
	import adc_ctrl_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       resetn,
	input wire logic [7:0] green_in,
	input wire logic [7:0] blue_in,
	input wire logic       line_sync_in,
	input wire logic       frame_sync_in,
	input wire logic       out_enable_n,
	input wire logic [7:0] green_out,
	input wire logic [7:0] blue_out,
	input wire logic       data_oe_n,
	input wire logic [1:0] dither_offset,
	input wire logic [2:0] clamp_sink,
	input wire logic [2:0] clamp_source
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	function automatic logic [7:0] fix(logic [7:0] s, logic [1:0] d);
		if (d[1])
			return (s == 8'h00) ? 8'h00 : s - 8'h01;
		return (s == 8'h00) ? 8'h01 : s;
	endfunction
	// stages may still hold reset data
	sequence warm; $past(resetn) && $past(resetn, 2) && $past(resetn, 3); endsequence
	sequence line_fall; $fell(line_sync_in); endsequence
	a_green_pipe: assert property (warm |-> green_out ==
		fix($past(green_in, 3), $past(dither_offset, 3))) else $error("green code");
	a_blue_pipe: assert property (warm |-> blue_out ==
		fix($past(blue_in, 3), $past(dither_offset, 3))) else $error("blue code");
	a_line_step: assert property ($rose(line_sync_in) && frame_sync_in && $past(frame_sync_in)
		|=> !frame_sync_in || dither_offset == $past(dither_offset) + 2'h1) else $error("step");
	a_dither_gate: assert property (!frame_sync_in |-> dither_offset == 2'h0)
		else $error("dither on");
	a_clamp_fire: assert property (line_fall |=> line_sync_in ||
		(clamp_sink ^ clamp_source) == 3'h7) else $error("no correction");
	a_clamp_hold: assert property (!line_sync_in && $past(resetn) &&
		$past(clamp_sink | clamp_source) != 3'h0 |-> $stable(clamp_sink)) else $error("hold");
	a_clamp_idle: assert property (line_sync_in |-> (clamp_sink | clamp_source) == 3'h0)
		else $error("idle");
	a_oe_follow: assert property (data_oe_n == out_enable_n) else $error("enable");
endmodule
bind video_adc_dither_clamp_control vadc_checker u_chk (.clk_sys, .resetn, .green_in,
	.blue_in, .line_sync_in, .frame_sync_in, .out_enable_n, .green_out, .blue_out,
	.data_oe_n, .dither_offset, .clamp_sink, .clamp_source);

// File: video_sink.sv
// Purpose: downstream sink on the output bus
// Assumes: words change at rising edges
// Notes: a released bus reads as the inverse of the last word
module video_sink (
	input  wire logic        clk_sys,
	input  wire logic [23:0] word_in,
	input  wire logic        oe_n,
	output logic      [23:0] bus
);
	logic [23:0] last;
	assign bus = oe_n ? ~last : word_in;
	always_ff @(posedge clk_sys)
		if (!oe_n) last <= word_in;
endmodule

// File: video_adc_dither_clamp_control_bench.sv
// Purpose: directed scenarios for the converter control
// Assumes: clk_en held high
// Notes: two-bit dither count
module video_adc_dither_clamp_control_bench
	import adc_ctrl_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, resetn, clk_en, line_sync_in, frame_sync_in, out_enable_n;
	logic [7:0]  green_in, red_in, blue_in, green_out, red_out, blue_out;
	logic [1:0]  dither_offset;
	logic [2:0]  clamp_sink, clamp_source;
	logic [23:0] bus;
	logic        data_oe_n;
	clamp_mode_t clamp_mode;
	int          miscompares = 0, comparisons = 0;
	video_adc_dither_clamp_control u_dut (.clk_sys, .resetn, .clk_en, .green_in, .red_in,
		.blue_in, .line_sync_in, .frame_sync_in, .clamp_mode, .out_enable_n, .green_out,
		.red_out, .blue_out, .data_oe_n, .dither_offset, .clamp_sink, .clamp_source);
	video_sink u_sink (.clk_sys, .word_in({green_out, red_out, blue_out}), .oe_n(data_oe_n), .bus);
	task automatic cmp(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic put(input logic [23:0] w);
		{green_in, red_in, blue_in} <= w;
	endtask
	task automatic pulse;
		tick(1);
		line_sync_in <= 1'b1;
		tick(2);
		line_sync_in <= 1'b0;
		tick(3);
	endtask
	task automatic t_pipe;
		put(24'h01FF80);
		tick(4);
		put(24'h7F0010);
		tick(2);
		#1 cmp(bus, 24'h01FF80);
		tick(1);
		#1 cmp(bus, 24'h7F0110);
	endtask
	task automatic t_clamp(input clamp_mode_t m, input logic [5:0] exp);
		tick(1);
		clamp_mode <= m;
		put(24'h306060);
		line_sync_in <= 1'b1;
		tick(5);
		#1 cmp({18'h0, clamp_sink, clamp_source}, 24'h0);
		tick(1);
		line_sync_in <= 1'b0;
		tick(2);
		#1 cmp({18'h0, clamp_sink, clamp_source}, {18'h0, exp});
	endtask
	task automatic t_dither;
		tick(1);
		frame_sync_in <= 1'b1;
		put(24'h0100FF);
		for (int c = 1; c < 5; c++) begin
			pulse();
			#1 cmp({22'h0, dither_offset}, {22'h0, c[1:0]});
			cmp(bus, c[1] ? 24'h0000FE : 24'h0101FF);
		end
		pulse();
	endtask
	task automatic t_frame;
		frame_sync_in <= 1'b0;
		tick(2);
		#1 cmp({22'h0, dither_offset}, 24'h0);
		pulse();
		frame_sync_in <= 1'b1;
		pulse();
		#1 cmp({22'h0, dither_offset}, 24'h1);
		tick(1);
		frame_sync_in <= 1'b0;
		tick(2);
		frame_sync_in <= 1'b1;
		tick(2);
		#1 cmp({22'h0, dither_offset}, 24'h1);
	endtask
	task automatic t_float;
		tick(1);
		out_enable_n <= 1'b1;
		tick(2);
		#1 cmp({23'h0, data_oe_n}, 24'h1);
		cmp({23'h0, bus === {green_out, red_out, blue_out}}, 24'h0);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		line_sync_in = 1'b0;
		frame_sync_in = 1'b1;
		out_enable_n = 1'b0;
		clamp_mode = MODE_LOW;
		{green_in, red_in, blue_in} = 24'h0;
		tick(6);
		resetn <= 1'b1;
		tick(1);
		frame_sync_in <= 1'b0;
		t_pipe();
		t_clamp(MODE_LOW, 6'h38);
		t_clamp(MODE_HIGH, 6'h0E);
		t_clamp(MODE_OPEN, 6'h07);
		t_dither();
		t_frame();
		t_float();
		summarize();
	end
endmodule
